//--- verilog/ddpc_pkg.sv
// Constants, register map and types of the dual DAC playback port control
// ============================================================
// Overview of operation
// - Three-bit ratio field: 000 auto detect as slave, 256 fs as master; 001..111 pick 128..1152 fs.
// - Bit clock field: MCLK/4, MCLK/8, 32fs, 64fs, 128fs; others reserved.
// - DAC1 mode bit 1 drives port 1 clocks out, 0 takes them in.
// - DAC2 mode bit does the same for port 2, independent of DAC1.
// - DAC1 volume code 0 is -100dB, 0.5dB per code, 0xc8 is 0dB.
// - Code 0xdf gives +11.5dB; any code 111xxxxx gives +12dB.
// - DAC1 volume registers hold apply bit 8 over code 7:0, DAC2 volume has none; all codes reset 0xc8.
// - DAC2 word length 16/20/24/32; 32 bits not with right justified.
// - DAC2 bit clock invert 0 samples on rise, 1 on fall.
// - DAC2 zero cross enabled defers volume change to a zero crossing.
// - DAC2 power bit turns the second DAC on or off alone.
// - DAC2 soft silence ramps the output down instead of cutting it.
// - Control 2 holds rate in 5:3, ratio in 2:0, resets to zero.
// - Format 00 right, 01 left justified, 10 I2S, 11 DSP.
package ddpc_pkg;
	localparam logic [3:0]  ADDR_DAC1_CLK_RATIO = 4'h3;
	localparam logic [3:0]  ADDR_DAC1_CLK_MODE  = 4'h4;
	localparam logic [3:0]  ADDR_DAC1_LEFT_VOL  = 4'h5;
	localparam logic [3:0]  ADDR_DAC1_RIGHT_VOL = 4'h6;
	localparam logic [3:0]  ADDR_DAC2_FORMAT    = 4'h7;
	localparam logic [3:0]  ADDR_DAC2_CLK_RATIO = 4'h8;
	localparam logic [3:0]  ADDR_DAC2_CLK_MODE  = 4'h9;
	localparam logic [3:0]  ADDR_DAC2_VOLUME    = 4'ha;
	localparam logic [3:0]  ADDR_STATUS         = 4'hf;
	localparam int          VOL_APPLY_BIT       = 8;
	localparam logic [7:0]  VOL_RESET           = 8'hc8;
	localparam logic [7:0]  VOL_MAX_CODE        = 8'he0;
	localparam logic [15:0] FMT_RESET           = 16'h008a;
	localparam int          FMT_FORMAT_LSB      = 0;
	localparam int          FMT_LENGTH_LSB      = 2;
	localparam int          FMT_BCLK_INV_BIT    = 4;
	localparam int          FMT_ZC_BIT          = 7;
	localparam int          FMT_POWER_BIT       = 8;
	localparam int          FMT_SILENCE_BIT     = 9;
	localparam int          CR_RATIO_LSB        = 0;
	localparam int          CR_RATE_LSB         = 3;
	localparam logic [1:0]  FORMAT_RIGHT_JUST   = 2'h0;
	localparam logic [1:0]  LENGTH_32           = 2'h3;
	localparam logic [2:0]  RATIO_AUTO          = 3'h0;
	localparam logic [2:0]  RATE_MAX_CODE       = 3'h4;
	localparam int          MCLK_COUNT_W        = 12;
	localparam int          RAMP_STEP_W         = 8;
	typedef enum logic [1:0] {DDPC_IDLE, DDPC_MEASURE, DDPC_LOCKED}
		ddpc_det_t;
	// Multiples of fs for ratio codes 1..7
	function automatic logic [10:0] ddpc_ratio_fs(input logic [2:0] code);
		unique case (code)
			3'h1: ddpc_ratio_fs = 11'h080;
			3'h2: ddpc_ratio_fs = 11'h0c0;
			3'h3: ddpc_ratio_fs = 11'h100;
			3'h4: ddpc_ratio_fs = 11'h180;
			3'h5: ddpc_ratio_fs = 11'h200;
			3'h6: ddpc_ratio_fs = 11'h300;
			3'h7: ddpc_ratio_fs = 11'h480;
			default: ddpc_ratio_fs = 11'h000;
		endcase
	endfunction
endpackage

//--- verilog/ddpc_port_clk.sv
// One playback port: clock generation, ratio detection and data sampling
`timescale 1ns/1ps
`default_nettype none
module ddpc_port_clk import ddpc_pkg::*; #(
	parameter int CW = MCLK_COUNT_W
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       master_i,
	input  wire logic [2:0] ratio_i,
	input  wire logic [2:0] rate_i,
	input  wire logic       bclk_inv_i,
	input  wire logic       bclk_pin_i,
	input  wire logic       lrclk_pin_i,
	input  wire logic       data_pin_i,
	output var  logic       bclk_o,
	output var  logic       lrclk_o,
	output var  logic       sample_o,
	output var  logic       frame_o,
	output var  logic [2:0] ratio_used_o,
	output var  logic       locked_o
);
	// ============================================================
	// State
	typedef struct packed {
		logic [2:0]    bs;
		logic [2:0]    ls;
		logic [2:0]    ds;
		logic [CW-1:0] div;
		logic [CW-1:0] frm;
		logic [CW-1:0] meas;
		logic          bclk;
		logic          lrclk;
		logic          sample;
		logic          frame;
		logic [2:0]    used;
		ddpc_det_t     det;
	} ddpc_pc_t;
	ddpc_pc_t s_q, s_d;
	logic [CW-1:0] frame_len;
	logic [CW-1:0] half_bclk;
	logic [2:0]    eff;
	logic          b_prev, b_now, l_prev, l_now, edge_ok, l_edge;
	logic [2:0]    found;
	// ============================================================
	// Combinational update
	always_comb begin
		s_d = s_q;
		eff = (ratio_i == RATIO_AUTO) ? s_q.used : ratio_i;
		frame_len = CW'(ddpc_ratio_fs(eff));
		unique case (rate_i)
			3'h0: half_bclk = CW'(2);
			3'h1: half_bclk = CW'(4);
			3'h2: half_bclk = frame_len >> 6;
			3'h3: half_bclk = frame_len >> 7;
			3'h4: half_bclk = frame_len >> 8;
			default: half_bclk = CW'(2);
		endcase
		if (half_bclk == '0)
			half_bclk = CW'(1);
		s_d.bs = {s_q.bs[1:0], bclk_pin_i};
		s_d.ls = {s_q.ls[1:0], lrclk_pin_i};
		s_d.ds = {s_q.ds[1:0], data_pin_i};
		b_prev = s_q.bs[2];
		b_now  = s_q.bs[1];
		l_prev = s_q.ls[2];
		l_now  = s_q.ls[1];
		if (master_i) begin
			b_prev = s_q.bclk;
			b_now  = s_d.bclk;
			l_prev = s_q.lrclk;
			l_now  = s_d.lrclk;
			if (frame_len == '0) begin
				s_d.bclk = 1'b0;
				s_d.lrclk = 1'b0;
				s_d.div = '0;
				s_d.frm = '0;
			end else begin
				s_d.div = s_q.div + CW'(1);
				if (s_q.div + CW'(1) >= half_bclk) begin
					s_d.div = '0;
					s_d.bclk = ~s_q.bclk;
				end
				s_d.frm = s_q.frm + CW'(1);
				if (s_q.frm + CW'(1) >= (frame_len >> 1)) begin
					s_d.frm = '0;
					s_d.lrclk = ~s_q.lrclk;
				end
			end
			b_now = s_d.bclk;
			l_now = s_d.lrclk;
		end
		edge_ok = bclk_inv_i ? (b_prev & ~b_now) : (~b_prev & b_now);
		s_d.sample = edge_ok ? s_q.ds[1] : s_q.sample;
		l_edge = ~l_prev & l_now;
		s_d.frame = l_edge;
		found = 3'h0;
		for (int i = 1; i < 8; i++) begin
			// The closing edge cycle belongs to the period as well
			if (CW'(ddpc_ratio_fs(3'(i))) == s_q.meas + CW'(1))
				found = 3'(i);
		end
		unique case (s_q.det)
			DDPC_IDLE: begin
				s_d.meas = '0;
				if (!master_i && ratio_i == RATIO_AUTO && l_edge)
					s_d.det = DDPC_MEASURE;
			end
			DDPC_MEASURE: begin
				s_d.meas = s_q.meas + CW'(1);
				if (l_edge) begin
					s_d.meas = '0;
					if (found != 3'h0) begin
						s_d.used = found;
						s_d.det = DDPC_LOCKED;
					end
				end
			end
			DDPC_LOCKED: begin
				if (master_i || ratio_i != RATIO_AUTO)
					s_d.det = DDPC_IDLE;
			end
		endcase
		if (master_i && ratio_i == RATIO_AUTO)
			s_d.used = 3'h3;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign bclk_o       = s_q.bclk;
	assign lrclk_o      = s_q.lrclk;
	assign sample_o     = s_q.sample;
	assign frame_o      = s_q.frame;
	assign ratio_used_o = eff;
	assign locked_o     = (ratio_i != RATIO_AUTO) || master_i ||
		(s_q.det == DDPC_LOCKED);
endmodule
`default_nettype wire

//--- verilog/ddpc_top.sv
// Register file and playback control of two DAC serial ports
`timescale 1ns/1ps
`default_nettype none
module ddpc_top import ddpc_pkg::*; (
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [15:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output var  logic [15:0] RDATA_O,
	input  wire logic        PORT1_BIT_CLOCK_I,
	output var  logic        PORT1_BIT_CLOCK_O,
	output var  logic        PORT1_BIT_CLOCK_OE_O,
	input  wire logic        PORT1_FRAME_CLOCK_I,
	output var  logic        PORT1_FRAME_CLOCK_O,
	output var  logic        PORT1_FRAME_CLOCK_OE_O,
	input  wire logic        PORT1_DATA_I,
	input  wire logic        PORT2_BIT_CLOCK_I,
	output var  logic        PORT2_BIT_CLOCK_O,
	output var  logic        PORT2_BIT_CLOCK_OE_O,
	input  wire logic        PORT2_FRAME_CLOCK_I,
	output var  logic        PORT2_FRAME_CLOCK_O,
	output var  logic        PORT2_FRAME_CLOCK_OE_O,
	input  wire logic        PORT2_DATA_I,
	input  wire logic        DAC2_AT_ZERO_I,
	output var  logic [7:0]  DAC1_LEFT_GAIN_O,
	output var  logic [7:0]  DAC1_RIGHT_GAIN_O,
	output var  logic [7:0]  DAC2_GAIN_O,
	output var  logic [7:0]  DAC2_LEVEL_O,
	output var  logic        DAC2_POWER_ON_O,
	output var  logic [1:0]  DAC2_FRAME_FORMAT_O,
	output var  logic [1:0]  DAC2_WORD_LENGTH_O,
	output var  logic        DAC1_SAMPLE_O,
	output var  logic        DAC2_SAMPLE_O
);
	// ============================================================
	// State
	typedef struct packed {
		logic [5:0]  dac1_cr;
		logic        dac1_clk_master_sel;
		logic [7:0]  dac1_left_gain;
		logic [7:0]  dac1_right_gain;
		logic [7:0]  dac1_left_live;
		logic [7:0]  dac1_right_live;
		logic [15:0] dac2_frame_format;
		logic [5:0]  dac2_cr;
		logic        dac2_clk_master_sel;
		logic [7:0]  dac2_gain_stored;
		logic        dac2_pending;
		logic [7:0]  dac2_gain_live;
		logic [7:0]  dac2_level;
		logic [RAMP_STEP_W-1:0] ramp_div;
		logic [15:0] rdata;
		logic        bad_fmt;
		logic        s1, s2;
		logic        b1, l1, b2, l2, oe1, oe2;
	} ddpc_top_t;
	ddpc_top_t s_q, s_d;
	logic        p1_b, p1_l, p1_s, p1_lock, p2_b, p2_l, p2_s, p2_lock;
	logic [2:0]  p1_used, p2_used;
	logic        zc_q, zc_d;
	logic [2:0]  zc_sync;
	logic        dac2_power_on, dac2_soft_silence;
	logic [7:0]  gain_target;
	logic [15:0] rd;
	// ============================================================
	// Ports
	ddpc_port_clk u_port1 (
		.clk_i        (CLK_I),
		.reset_i      (RESET_I),
		.master_i     (s_q.dac1_clk_master_sel),
		.ratio_i      (s_q.dac1_cr[CR_RATIO_LSB +: 3]),
		.rate_i       (s_q.dac1_cr[CR_RATE_LSB +: 3]),
		.bclk_inv_i   (1'b0),
		.bclk_pin_i   (PORT1_BIT_CLOCK_I),
		.lrclk_pin_i  (PORT1_FRAME_CLOCK_I),
		.data_pin_i   (PORT1_DATA_I),
		.bclk_o       (p1_b),
		.lrclk_o      (p1_l),
		.sample_o     (p1_s),
		.frame_o      (),
		.ratio_used_o (p1_used),
		.locked_o     (p1_lock)
	);
	ddpc_port_clk u_port2 (
		.clk_i        (CLK_I),
		.reset_i      (RESET_I),
		.master_i     (s_q.dac2_clk_master_sel),
		.ratio_i      (s_q.dac2_cr[CR_RATIO_LSB +: 3]),
		.rate_i       (s_q.dac2_cr[CR_RATE_LSB +: 3]),
		.bclk_inv_i   (s_q.dac2_frame_format[FMT_BCLK_INV_BIT]),
		.bclk_pin_i   (PORT2_BIT_CLOCK_I),
		.lrclk_pin_i  (PORT2_FRAME_CLOCK_I),
		.data_pin_i   (PORT2_DATA_I),
		.bclk_o       (p2_b),
		.lrclk_o      (p2_l),
		.sample_o     (p2_s),
		.frame_o      (),
		.ratio_used_o (p2_used),
		.locked_o     (p2_lock)
	);
	// ============================================================
	// Zero crossing pin synchroniser
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			zc_sync <= '0;
			zc_q <= 1'b0;
		end else begin
			zc_sync <= {zc_sync[1:0], DAC2_AT_ZERO_I};
			zc_q <= zc_d;
		end
	end
	always_comb begin
		zc_d = zc_q;
		if (zc_sync[2] == zc_sync[1])
			zc_d = zc_sync[1];
	end
	// Codes at or above 111xxxxx saturate at +12dB; clipped when made live
	function automatic logic [7:0] ddpc_clip(input logic [7:0] c);
		ddpc_clip = (c >= VOL_MAX_CODE) ? VOL_MAX_CODE : c;
	endfunction
	// ============================================================
	// Register file and control
	always_comb begin
		s_d = s_q;
		dac2_power_on   = s_q.dac2_frame_format[FMT_POWER_BIT];
		dac2_soft_silence = s_q.dac2_frame_format[FMT_SILENCE_BIT];
		if (WR_I) begin
			unique case (ADDR_I)
				ADDR_DAC1_CLK_RATIO: s_d.dac1_cr = WDATA_I[5:0];
				ADDR_DAC1_CLK_MODE:
					s_d.dac1_clk_master_sel = WDATA_I[0];
				ADDR_DAC1_LEFT_VOL: begin
					s_d.dac1_left_gain = WDATA_I[7:0];
					if (WDATA_I[VOL_APPLY_BIT]) begin
						s_d.dac1_left_live  = ddpc_clip(WDATA_I[7:0]);
						s_d.dac1_right_live = ddpc_clip(s_q.dac1_right_gain);
					end
				end
				ADDR_DAC1_RIGHT_VOL: begin
					s_d.dac1_right_gain = WDATA_I[7:0];
					if (WDATA_I[VOL_APPLY_BIT]) begin
						s_d.dac1_left_live  = ddpc_clip(s_q.dac1_left_gain);
						s_d.dac1_right_live = ddpc_clip(WDATA_I[7:0]);
					end
				end
				ADDR_DAC2_FORMAT: s_d.dac2_frame_format = {6'h00, WDATA_I[9:0]};
				ADDR_DAC2_CLK_RATIO: s_d.dac2_cr = WDATA_I[5:0];
				ADDR_DAC2_CLK_MODE:
					s_d.dac2_clk_master_sel = WDATA_I[0];
				ADDR_DAC2_VOLUME: begin
					s_d.dac2_gain_stored = WDATA_I[7:0];
					s_d.dac2_pending = 1'b1;
				end
				default: ;
			endcase
		end
		// Report the unsupported 32-bit right justified combination
		s_d.bad_fmt = (s_d.dac2_frame_format[FMT_LENGTH_LSB +: 2] == LENGTH_32) &&
			(s_d.dac2_frame_format[FMT_FORMAT_LSB +: 2] == FORMAT_RIGHT_JUST);
		if (s_q.dac2_pending &&
			(!s_q.dac2_frame_format[FMT_ZC_BIT] || zc_q)) begin
			s_d.dac2_gain_live = ddpc_clip(s_q.dac2_gain_stored);
			s_d.dac2_pending = (WR_I && ADDR_I == ADDR_DAC2_VOLUME);
		end
		// Ramp the level one code per step toward the target
		gain_target = (!dac2_power_on || dac2_soft_silence) ? 8'h00 :
			s_q.dac2_gain_live;
		s_d.ramp_div = s_q.ramp_div + RAMP_STEP_W'(1);
		if (s_q.ramp_div == '1) begin
			if (s_q.dac2_level > gain_target)
				s_d.dac2_level = s_q.dac2_level - 8'h01;
			else if (s_q.dac2_level < gain_target)
				s_d.dac2_level = s_q.dac2_level + 8'h01;
		end
		if (!dac2_power_on)
			s_d.dac2_level = 8'h00;
		rd = 16'h0000;
		unique case (ADDR_I)
			ADDR_DAC1_CLK_RATIO: rd = {10'h000, s_q.dac1_cr};
			ADDR_DAC1_CLK_MODE:  rd = {15'h0000, s_q.dac1_clk_master_sel};
			ADDR_DAC1_LEFT_VOL:  rd = {8'h00, s_q.dac1_left_gain};
			ADDR_DAC1_RIGHT_VOL: rd = {8'h00, s_q.dac1_right_gain};
			ADDR_DAC2_FORMAT:    rd = s_q.dac2_frame_format;
			ADDR_DAC2_CLK_RATIO: rd = {10'h000, s_q.dac2_cr};
			ADDR_DAC2_CLK_MODE:  rd = {15'h0000, s_q.dac2_clk_master_sel};
			ADDR_DAC2_VOLUME:    rd = {7'h00, s_q.dac2_pending,
				s_q.dac2_gain_stored};
			ADDR_STATUS: rd = {5'h00, s_q.bad_fmt, p2_used, p1_used,
				p2_lock, p1_lock, 2'h0};
			default: rd = 16'h0000;
		endcase
		s_d.rdata = RD_I ? rd : 16'h0000;
		s_d.b1 = p1_b;
		s_d.l1 = p1_l;
		s_d.b2 = p2_b;
		s_d.l2 = p2_l;
		s_d.oe1 = s_q.dac1_clk_master_sel;
		s_d.oe2 = s_q.dac2_clk_master_sel;
		s_d.s1 = p1_s;
		s_d.s2 = p2_s & dac2_power_on;
	end
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			s_q <= '0;
			s_q.dac1_left_gain  <= VOL_RESET;
			s_q.dac1_right_gain <= VOL_RESET;
			s_q.dac1_left_live  <= VOL_RESET;
			s_q.dac1_right_live <= VOL_RESET;
			s_q.dac2_gain_stored <= VOL_RESET;
			s_q.dac2_gain_live  <= VOL_RESET;
			s_q.dac2_frame_format <= FMT_RESET;
		end else begin
			s_q <= s_d;
		end
	end
	assign RDATA_O = s_q.rdata;
	assign PORT1_BIT_CLOCK_O = s_q.b1;
	assign PORT1_FRAME_CLOCK_O = s_q.l1;
	assign PORT1_BIT_CLOCK_OE_O = s_q.oe1;
	assign PORT1_FRAME_CLOCK_OE_O = s_q.oe1;
	assign PORT2_BIT_CLOCK_O = s_q.b2;
	assign PORT2_FRAME_CLOCK_O = s_q.l2;
	assign PORT2_BIT_CLOCK_OE_O = s_q.oe2;
	assign PORT2_FRAME_CLOCK_OE_O = s_q.oe2;
	assign DAC1_LEFT_GAIN_O = s_q.dac1_left_live;
	assign DAC1_RIGHT_GAIN_O = s_q.dac1_right_live;
	assign DAC2_GAIN_O = s_q.dac2_gain_live;
	// Level only ramps toward a clipped target, so it needs no clip
	assign DAC2_LEVEL_O = s_q.dac2_level;
	assign DAC2_POWER_ON_O = s_q.dac2_frame_format[FMT_POWER_BIT];
	assign DAC2_FRAME_FORMAT_O = s_q.dac2_frame_format[FMT_FORMAT_LSB +: 2];
	assign DAC2_WORD_LENGTH_O = s_q.dac2_frame_format[FMT_LENGTH_LSB +: 2];
	assign DAC1_SAMPLE_O = s_q.s1;
	assign DAC2_SAMPLE_O = s_q.s2;
	// ============================================================
	// Checks
	a_vol_reset: assert property (@(posedge CLK_I)
		$fell(RESET_I) |-> DAC1_LEFT_GAIN_O == VOL_RESET)
		else $error("DAC1 left gain not at reset code");
	a_apply_both: assert property (@(posedge CLK_I) disable iff (RESET_I)
		WR_I && ADDR_I == ADDR_DAC1_LEFT_VOL && WDATA_I[VOL_APPLY_BIT]
		|=> DAC1_LEFT_GAIN_O == ddpc_clip($past(WDATA_I[7:0])) &&
		DAC1_RIGHT_GAIN_O == ddpc_clip(s_q.dac1_right_gain))
		else $error("Apply did not update both channels");
	a_store_only: assert property (@(posedge CLK_I) disable iff (RESET_I)
		WR_I && ADDR_I == ADDR_DAC1_RIGHT_VOL && !WDATA_I[VOL_APPLY_BIT]
		|=> $stable(DAC1_RIGHT_GAIN_O))
		else $error("Store-only write changed live gain");
	a_gain_clip: assert property (@(posedge CLK_I) disable iff (RESET_I)
		DAC1_LEFT_GAIN_O <= VOL_MAX_CODE)
		else $error("Gain above saturation code");
	a_master_oe: assert property (@(posedge CLK_I) disable iff (RESET_I)
		WR_I && ADDR_I == ADDR_DAC1_CLK_MODE ##1 !WR_I
		|=> PORT1_BIT_CLOCK_OE_O == $past(WDATA_I[0], 2))
		else $error("Port 1 drive enable does not follow mode");
	a_slave_oe2: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!s_q.dac2_clk_master_sel [*2] |-> !PORT2_FRAME_CLOCK_OE_O)
		else $error("Port 2 driven in slave mode");
	a_zc_wait: assert property (@(posedge CLK_I) disable iff (RESET_I)
		s_q.dac2_pending && s_q.dac2_frame_format[FMT_ZC_BIT] && !zc_q
		|=> $stable(s_q.dac2_gain_live))
		else $error("DAC2 gain changed away from zero crossing");
	a_power_off: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!DAC2_POWER_ON_O |=> DAC2_LEVEL_O == 8'h00)
		else $error("DAC2 level while powered off");
	a_ramp_step: assert property (@(posedge CLK_I) disable iff (RESET_I)
		DAC2_POWER_ON_O && $past(DAC2_POWER_ON_O) &&
		s_q.dac2_frame_format[FMT_SILENCE_BIT]
		|-> 9'(s_q.dac2_level) + 9'h001 >= 9'($past(s_q.dac2_level)))
		else $error("Soft silence cut the level abruptly");
	a_rate_zero: assert property (@(posedge CLK_I) disable iff (RESET_I)
		RD_I && ADDR_I == ADDR_DAC2_CLK_RATIO |=> RDATA_O[15:6] == 10'h000)
		else $error("Upper control bits not zero");
	a_store_left: assert property (@(posedge CLK_I) disable iff (RESET_I)
		WR_I && ADDR_I == ADDR_DAC1_LEFT_VOL && !WDATA_I[VOL_APPLY_BIT]
		|=> $stable(DAC1_LEFT_GAIN_O))
		else $error("Store-only write changed live left gain");
	a_zc_apply: assert property (@(posedge CLK_I) disable iff (RESET_I)
		s_q.dac2_pending && !s_q.dac2_frame_format[FMT_ZC_BIT]
		|=> DAC2_GAIN_O == ddpc_clip($past(s_q.dac2_gain_stored)))
		else $error("DAC2 gain not applied at once");
	a_power_field: assert property (@(posedge CLK_I) disable iff (RESET_I)
		WR_I && ADDR_I == ADDR_DAC2_FORMAT
		|=> DAC2_POWER_ON_O == $past(WDATA_I[FMT_POWER_BIT]))
		else $error("DAC2 power does not follow its bit");
	a_sample_off: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!DAC2_POWER_ON_O |=> !DAC2_SAMPLE_O)
		else $error("DAC2 sample while powered off");
	a_bad_combo: assert property (@(posedge CLK_I) disable iff (RESET_I)
		RD_I && ADDR_I == ADDR_STATUS |=> RDATA_O[10] ==
		(DAC2_WORD_LENGTH_O == LENGTH_32 &&
		DAC2_FRAME_FORMAT_O == FORMAT_RIGHT_JUST))
		else $error("Unsupported format flag wrong");
	c_apply: cover property (@(posedge CLK_I)
		WR_I && ADDR_I == ADDR_DAC1_LEFT_VOL && WDATA_I[VOL_APPLY_BIT]);
	c_master: cover property (@(posedge CLK_I) PORT2_BIT_CLOCK_OE_O);
	c_lock: cover property (@(posedge CLK_I) $rose(p1_lock));
	c_silence: cover property (@(posedge CLK_I)
		s_q.dac2_frame_format[FMT_SILENCE_BIT] && DAC2_LEVEL_O != 8'h00);
	c_zero_cross: cover property (@(posedge CLK_I)
		s_q.dac2_pending && s_q.dac2_frame_format[FMT_ZC_BIT] && zc_q);
endmodule
`default_nettype wire

//--- tb/ddpc_src_model.sv
// Far-side audio source: slave-mode bit clock, frame clock and data
`timescale 1ns/1ps
`default_nettype none
module ddpc_src_model #(
	parameter int FRAME_CYC = 128
) (
	input  wire logic clk_i,
	input  wire logic run_i,
	output var  logic bclk_o,
	output var  logic lrclk_o,
	output var  logic data_o
);
	int   cnt_q = 0;
	logic tgl_q = 1'b0;
	// ============================================================
	// Frame timing: eight cycles per bit, data high in mid bit
	always_ff @(posedge clk_i) begin
		tgl_q <= ~tgl_q;
		if (run_i) begin
			cnt_q <= (cnt_q + 1) % FRAME_CYC;
		end
		else begin
			cnt_q <= 0;
		end
	end
	// Clocks stand still outside frames; idle data changes every cycle
	always_comb begin
		bclk_o  = run_i && (cnt_q % 8 < 4);
		lrclk_o = run_i && (cnt_q < FRAME_CYC / 2);
		data_o  = run_i ? (cnt_q % 8 >= 2 && cnt_q % 8 < 6) : tgl_q;
	end
endmodule
`default_nettype wire

//--- tb/ddpc_top_tb_top.sv
// Self-checking testbench of the dual DAC playback port control
`timescale 1ns/1ps
`default_nettype none
module ddpc_top_tb_top;
	logic        CLK_I = 1'b0;
	logic        RESET_I = 1'b1;
	logic [3:0]  ADDR_I = 4'h0;
	logic [15:0] WDATA_I = 16'h0000;
	logic        WR_I = 1'b0;
	logic        RD_I = 1'b0;
	logic        DAC2_AT_ZERO_I = 1'b0;
	logic [15:0] RDATA_O;
	logic        p1b_o, p1b_oe, p1f_o, p1f_oe, p2b_o, p2b_oe, p2f_o, p2f_oe;
	logic        m1b, m1f, m1d, m2b, m2f, m2d;
	logic [7:0]  gl, gr, g2, lvl2;
	logic        pwr2, smp1, smp2;
	logic [1:0]  fmt2, wl2;
	int          bad_count = 0;
	int          check_count = 0;
	wire logic   p1b = p1b_oe ? p1b_o : m1b;
	wire logic   p1f = p1f_oe ? p1f_o : m1f;
	wire logic   p2b = p2b_oe ? p2b_o : m2b;
	wire logic   p2f = p2f_oe ? p2f_o : m2f;
	// ============================================================
	// Design, far-side sources and clock
	ddpc_top uut (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
		.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
		.PORT1_BIT_CLOCK_I(p1b), .PORT1_BIT_CLOCK_O(p1b_o),
		.PORT1_BIT_CLOCK_OE_O(p1b_oe), .PORT1_FRAME_CLOCK_I(p1f),
		.PORT1_FRAME_CLOCK_O(p1f_o), .PORT1_FRAME_CLOCK_OE_O(p1f_oe),
		.PORT1_DATA_I(m1d), .PORT2_BIT_CLOCK_I(p2b),
		.PORT2_BIT_CLOCK_O(p2b_o), .PORT2_BIT_CLOCK_OE_O(p2b_oe),
		.PORT2_FRAME_CLOCK_I(p2f), .PORT2_FRAME_CLOCK_O(p2f_o),
		.PORT2_FRAME_CLOCK_OE_O(p2f_oe), .PORT2_DATA_I(m2d),
		.DAC2_AT_ZERO_I(DAC2_AT_ZERO_I), .DAC1_LEFT_GAIN_O(gl),
		.DAC1_RIGHT_GAIN_O(gr), .DAC2_GAIN_O(g2), .DAC2_LEVEL_O(lvl2),
		.DAC2_POWER_ON_O(pwr2), .DAC2_FRAME_FORMAT_O(fmt2),
		.DAC2_WORD_LENGTH_O(wl2), .DAC1_SAMPLE_O(smp1),
		.DAC2_SAMPLE_O(smp2));
	ddpc_src_model src1 (.clk_i(CLK_I), .run_i(!p1b_oe), .bclk_o(m1b),
		.lrclk_o(m1f), .data_o(m1d));
	ddpc_src_model src2 (.clk_i(CLK_I), .run_i(!p2b_oe), .bclk_o(m2b),
		.lrclk_o(m2f), .data_o(m2d));
	initial begin
		forever #2 CLK_I = ~CLK_I;
	end
	// ============================================================
	// Bus cycles, comparison and verdict
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		ADDR_I  <= a;
		WDATA_I <= d;
		WR_I    <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
		@(posedge CLK_I);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		ADDR_I <= a;
		RD_I   <= 1'b1;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1 d = RDATA_O;
		@(posedge CLK_I);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkr(input logic [3:0] a, input logic [15:0] m,
		input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(d & m, exp);
	endtask
	task automatic gains(input logic [7:0] l, input logic [7:0] r);
		@(posedge CLK_I);
		chk({gl, gr}, {l, r});
	endtask
	task automatic rises(input bit sel, input logic [15:0] eb,
		input logic [15:0] ef);
		logic [15:0] nb, nf;
		logic        pb, pf, cb, cf;
		nb = 16'h0000;
		nf = 16'h0000;
		repeat (300) @(posedge CLK_I);
		pb = sel ? p2b_o : p1b_o;
		pf = sel ? p2f_o : p1f_o;
		repeat (512) begin
			@(posedge CLK_I);
			cb = sel ? p2b_o : p1b_o;
			cf = sel ? p2f_o : p1f_o;
			nb += 16'(cb & ~pb);
			nf += 16'(cf & ~pf);
			pb = cb;
			pf = cf;
		end
		chk(nb, eb);
		chk(nf, ef);
	endtask
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end
		else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ============================================================
	// Scenarios
	task automatic t_reset;
		logic [15:0] e [3:9] = '{16'h0000, 16'h0000, 16'h00c8, 16'h00c8,
			16'h008a, 16'h0000, 16'h0000};
		for (int a = 3; a <= 9; a++) begin
			chkr(4'(a), 16'hffff, e[a]);
		end
		wr(4'h0, 16'hffff);
		chkr(4'h0, 16'hffff, 16'h0000);
		chk({gl, gr}, 16'hc8c8);
	endtask
	task automatic t_autodet;
		repeat (1000) @(posedge CLK_I);
		chkr(4'hf, 16'h03fc, 16'h009c);
	endtask
	task automatic t_ctrl2;
		wr(4'h3, 16'hffff);
		chkr(4'h3, 16'hffff, 16'h003f);
		wr(4'h8, 16'hffc9);
		chkr(4'h8, 16'hffff, 16'h0009);
		wr(4'h3, 16'h0000);
		wr(4'h8, 16'h0000);
	endtask
	task automatic t_volume;
		wr(4'h5, 16'h00c0);
		gains(8'hc8, 8'hc8);
		wr(4'h6, 16'h0150);
		gains(8'hc0, 8'h50);
		wr(4'h5, 16'h01f5);
		gains(8'he0, 8'h50);
		wr(4'h6, 16'h01df);
		gains(8'he0, 8'hdf);
		wr(4'h6, 16'h0030);
		gains(8'he0, 8'hdf);
		chkr(4'h5, 16'h00ff, 16'h00f5);
	endtask
	task automatic t_master;
		wr(4'h4, 16'h0001);
		repeat (2) @(posedge CLK_I);
		chk({p1b_oe, p1f_oe, p2b_oe, p2f_oe}, 16'h000c);
		rises(1'b0, 16'd128, 16'd2);
		wr(4'h3, 16'h0009);
		rises(1'b0, 16'd64, 16'd4);
		wr(4'h3, 16'h0011);
		rises(1'b0, 16'd128, 16'd4);
		wr(4'h9, 16'h0001);
		wr(4'h4, 16'h0000);
		repeat (2) @(posedge CLK_I);
		chk({p1b_oe, p1f_oe, p2b_oe, p2f_oe}, 16'h0003);
		rises(1'b1, 16'd128, 16'd2);
		wr(4'h9, 16'h0000);
		wr(4'h3, 16'h0000);
	endtask
	task automatic t_dac2;
		for (int v = 0; v < 16; v++) begin
			wr(4'h7, 16'h0100 | 16'(v));
			@(posedge CLK_I);
			chk({pwr2, wl2, fmt2}, 16'h0010 | 16'(v));
			chkr(4'hf, 16'h0400, (v == 12) ? 16'h0400 : 16'h0000);
		end
		wr(4'h7, 16'h0000);
		@(posedge CLK_I);
		chk({15'h0, pwr2}, 16'h0000);
		wr(4'h7, 16'h0180);
		wr(4'ha, 16'h0110);
		repeat (20) @(posedge CLK_I);
		chk({8'h0, g2}, 16'h00c8);
		DAC2_AT_ZERO_I <= 1'b1;
		for (int i = 0; i < 10 && g2 !== 8'h10; i++) @(posedge CLK_I);
		chk({8'h0, g2}, 16'h0010);
		DAC2_AT_ZERO_I <= 1'b0;
		wr(4'h7, 16'h0100);
		wr(4'ha, 16'h0120);
		repeat (3) @(posedge CLK_I);
		chk({8'h0, g2}, 16'h0020);
		repeat (64) @(posedge CLK_I);
		chk({14'h0, smp1, smp2}, 16'h0000);
		wr(4'h7, 16'h0110);
		repeat (64) @(posedge CLK_I);
		chk({15'h0, smp2}, 16'h0001);
	endtask
	task automatic t_silence;
		wr(4'h7, 16'h0000);
		@(posedge CLK_I);
		chk({8'h0, lvl2}, 16'h0000);
		wr(4'h7, 16'h0100);
		repeat (9000) @(posedge CLK_I);
		chk({8'h0, lvl2}, 16'h0020);
		wr(4'h7, 16'h0300);
		repeat (600) @(posedge CLK_I);
		chk(16'(lvl2 > 8'h1b && lvl2 < 8'h20), 16'h0001);
		repeat (9000) @(posedge CLK_I);
		chk({8'h0, lvl2}, 16'h0000);
	endtask
	initial begin
		repeat (16) @(posedge CLK_I);
		RESET_I <= 1'b0;
		@(posedge CLK_I);
		t_reset();
		t_autodet();
		t_ctrl2();
		t_volume();
		t_master();
		t_dac2();
		t_silence();
		results();
	end
	initial begin
		repeat (60000) @(posedge CLK_I);
		bad_count++;
		results();
	end
endmodule
`default_nettype wire
